// ---- logic/tws_core.sv ----
// two-wire serial register core with apb register slave and bus engine
//
// Operation
// RULE1 - enable bit takes the pins and switches slew limiting and filtering on; the core has no slew control, enable drives only filter_en
// RULE2 - clearing enable stops the unit and aborts any transfer at once
// RULE3 - reserved control bit 1 and status bit 2 read as zero
// RULE4 - irq is high while job-done, irq enable and global enable are set
// RULE5 - status code sits in bits 7..3, read with the prescale bits
// RULE6 - software masks the prescale bits before comparing status codes
// RULE7 - prescale field 1..0 is read/write, selects factor 1, 4, 16 or 64
// RULE8 - data register holds tx or rx byte, writable only while job-done
// RULE9 - data register stays unchanged while job-done is set, resets to ones
// RULE10 - bus data shifts in while a byte shifts out
// RULE11 - byte being received survives a lost arbitration
// RULE12 - acknowledge enable bit, written by the cpu, controls whether the acknowledge pulse is driven
// RULE13 - own seven-bit address from bits 7..1, used only as slave
// RULE14 - address bit 0 enables recognition of the general call address
// RULE15 - an address match raises the job-done flag and so an interrupt
// RULE16 - multimaster software programs the own address of addressable masters
// RULE17 - with irq enable clear, software polls the job-done flag
// RULE18 - job-done rises after every bus event, status shows bus state
// RULE19 - writing one clears job-done; no bus action while set, then proceeds
// RULE20 - after start, address or data, flag set and code shows ack
// RULE21 - master transmit: start, address, data, stop with checks between
// RULE22 - no job-done after a stop has been sent
// RULE23 - scl is held low while job-done is set
// RULE24 - status updates one cycle after job-done, else shows the idle code
// RULE25 - data write without job-done sets collision, with job-done clears it
// RULE26 - register access is synchronous; a flag clear reaches the engine next cycle
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tws_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tws_pkg::tws_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_en,
    output logic irq,
    output logic filter_en,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import tws_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    logic en_q, ie_q, acken_q, sta_q, sto_q, done_q, wc_q, clr_q;
    logic [1:0] ps_q;
    logic [7:0] rate_q, data_q, oaddr_q;
    logic [4:0] status_q, evt_c_q;
    logic evt_q, stop_done_q, busy_q, mstr_q, addr_ph_q, lost_q, ack_drv_q;
    logic scl_oe_q, sda_oe_q;
    tws_state_t state_q;
    logic [1:0] phase_q;
    logic [2:0] bitcnt_q;
    logic [15:0] cnt_q;
    logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] qtr_len(input logic [7:0] br, input logic [1:0] ps);
        logic [15:0] m;
        m = {8'h00, br} << {ps, 1'b0};
        return QTR_BASE + (m >> 1);
    endfunction : qtr_len

    // bit 1 own address, bit 0 general call
    function automatic logic [1:0] addr_hit(input logic [7:0] b, input logic [7:0] oa);
        addr_hit = {b[7:1] == oa[7:1], (b == GC_ADDR) && oa[ADR_GCE]};
    endfunction : addr_hit

    logic acc, wr, wr_ctrl, wr_data, tick, step;
    logic bus_start, bus_stop, scl_rise, scl_fall;
    logic [7:0] wd, byte_in;
    logic [1:0] hit;
    logic [31:0] rd_mux;
    logic mapped;

    assign acc = apb.psel && apb.penable;
    assign wr = acc && pready_q && apb.pwrite;
    assign wd = apb.pwdata[7:0];
    assign wr_ctrl = wr && apb.paddr == OFF_CTRL;
    assign wr_data = wr && apb.paddr == OFF_DATA;
    assign tick = en_q && cnt_q == 16'h0000;
    assign step = tick && (phase_q != 2'h2 || scl_s2);
    assign bus_start = scl_s2 && scl_p && sda_p && !sda_s2;
    assign bus_stop = scl_s2 && scl_p && !sda_p && sda_s2;
    assign scl_rise = scl_s2 && !scl_p;
    assign scl_fall = !scl_s2 && scl_p;
    assign byte_in = {data_q[6:0], sda_s2};
    assign hit = addr_hit(byte_in, oaddr_q); // RULE13 RULE14

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign filter_en = en_q; // RULE1
    // open-drain: the pads only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {scl_s1, scl_s2, scl_p} <= 3'h7;
            {sda_s1, sda_s2, sda_p} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_p} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_p} <= {sda_i, sda_s1, sda_s2};
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (apb.paddr)
            OFF_CTRL: rd_mux[7:0] = {done_q, acken_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q}; // RULE3 RULE12
            OFF_STAT: rd_mux[7:0] = {status_q, 1'b0, ps_q}; // RULE3 RULE5
            OFF_DATA: rd_mux[7:0] = data_q;
            OFF_ADDR: rd_mux[7:0] = oaddr_q;
            OFF_RATE: rd_mux[7:0] = rate_q;
            default: mapped = 1'b0;
        endcase
    end

    // one wait state: pready answers the second access cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !mapped;
            if (acc && !pready_q && !apb.pwrite) begin
                prdata_q <= rd_mux; // RULE26
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {en_q, ie_q, acken_q, sta_q, sto_q} <= 5'h00;
            ps_q <= RST_PS;
            rate_q <= RST_RATE;
            oaddr_q <= RST_ADDR;
        end else begin
            if (wr_ctrl) begin
                en_q <= wd[CTL_EN]; // RULE1 RULE2
                ie_q <= wd[CTL_IE];
                acken_q <= wd[CTL_ACKEN];
                sta_q <= wd[CTL_STA];
            end
            if (stop_done_q || !en_q) begin
                sto_q <= 1'b0;
            end else if (wr_ctrl) begin
                sto_q <= wd[CTL_STO];
            end
            if (wr && apb.paddr == OFF_STAT) begin
                ps_q <= wd[1:0]; // RULE7
            end
            if (wr && apb.paddr == OFF_RATE) begin
                rate_q <= wd;
            end
            if (wr && apb.paddr == OFF_ADDR) begin
                oaddr_q <= wd; // RULE13
            end
        end
    end

    // ----------------------------------------
    // job-done flag, collision, status, irq
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            // an event in the clearing cycle still sets the flag
            if (evt_q) begin
                done_q <= 1'b1; // RULE18
            end else if ((wr_ctrl && wd[CTL_DONE]) || !en_q) begin
                done_q <= 1'b0; // RULE19
            end
            clr_q <= wr_ctrl && wd[CTL_DONE] && done_q; // RULE26
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wc_q <= 1'b0;
        end else if (wr_data) begin
            wc_q <= !done_q; // RULE25
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q <= SC_NONE;
        end else begin
            status_q <= done_q ? evt_c_q : SC_NONE; // RULE24 RULE5
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && ie_q && global_irq_en; // RULE4 RULE15
        end
    end

    // ----------------------------------------
    // bit-rate divider and bus watch
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
        end else if (!en_q || cnt_q == 16'h0000) begin
            cnt_q <= qtr_len(rate_q, ps_q) - 16'h0001; // RULE7
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (!en_q || bus_stop) begin
            busy_q <= 1'b0;
        end else if (bus_start) begin
            busy_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // bus engine
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phase_q <= 2'h0;
            bitcnt_q <= 3'h0;
            data_q <= RST_DATA; // RULE9
            {scl_oe_q, sda_oe_q, mstr_q, addr_ph_q, lost_q, ack_drv_q} <= 6'h00;
            {evt_q, stop_done_q} <= 2'h0;
            evt_c_q <= SC_NONE;
        end else begin
            evt_q <= 1'b0;
            stop_done_q <= 1'b0;
            if (wr_data && done_q) begin
                data_q <= wd; // RULE8
            end
            if (!en_q) begin
                state_q <= ST_IDLE; // RULE2
                {scl_oe_q, sda_oe_q, mstr_q, lost_q} <= 4'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        scl_oe_q <= 1'b0;
                        sda_oe_q <= 1'b0;
                        phase_q <= 2'h0;
                        if (!done_q && sta_q && !busy_q) begin
                            state_q <= ST_START; // RULE19
                        end else if (bus_start) begin
                            state_q <= ST_SRX;
                            bitcnt_q <= 3'h7;
                            lost_q <= 1'b0;
                        end
                    end
                    ST_START: if (step) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_oe_q <= 1'b1;
                                evt_q <= 1'b1; // RULE20
                                evt_c_q <= mstr_q ? SC_RSTART : SC_START;
                                mstr_q <= 1'b1;
                                addr_ph_q <= 1'b1;
                                state_q <= ST_HOLD;
                            end
                        endcase
                    end
                    ST_TX: if (step) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: sda_oe_q <= !data_q[7];
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: scl_oe_q <= 1'b0;
                            default: begin
                                scl_oe_q <= 1'b1;
                                data_q <= byte_in; // RULE10
                                bitcnt_q <= bitcnt_q - 3'h1;
                                if (!sda_oe_q && !sda_s2) begin
                                    // lost: keep shifting as a slave, byte kept
                                    mstr_q <= 1'b0; // RULE11
                                    lost_q <= 1'b1;
                                    scl_oe_q <= 1'b0;
                                    sda_oe_q <= 1'b0;
                                    phase_q <= 2'h0;
                                    ack_drv_q <= 1'b0;
                                    evt_c_q <= SC_ARB;
                                    state_q <= (bitcnt_q == 3'h0) ? ST_SACK : ST_SRX;
                                end else if (bitcnt_q == 3'h0) begin
                                    state_q <= ST_ACK;
                                end
                            end
                        endcase
                    end
                    ST_ACK: if (step) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: sda_oe_q <= 1'b0; // RULE12
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: scl_oe_q <= 1'b0;
                            default: begin
                                scl_oe_q <= 1'b1;
                                evt_q <= 1'b1; // RULE20
                                if (addr_ph_q) begin
                                    evt_c_q <= sda_s2 ? SC_AW_NACK : SC_AW_ACK;
                                end else begin
                                    evt_c_q <= sda_s2 ? SC_D_NACK : SC_D_ACK;
                                end
                                addr_ph_q <= 1'b0;
                                state_q <= ST_HOLD;
                            end
                        endcase
                    end
                    ST_STOP: if (step) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: scl_oe_q <= 1'b0;
                            default: begin
                                sda_oe_q <= 1'b0;
                                mstr_q <= 1'b0;
                                stop_done_q <= 1'b1; // RULE22
                                state_q <= ST_IDLE;
                            end
                        endcase
                    end
                    ST_SRX: begin
                        if (bus_stop) begin
                            state_q <= ST_IDLE;
                        end else if (scl_rise) begin
                            data_q <= byte_in; // RULE11
                            bitcnt_q <= bitcnt_q - 3'h1;
                            if (bitcnt_q == 3'h0) begin
                                phase_q <= 2'h0;
                                ack_drv_q <= (|hit) && acken_q; // RULE12
                                if (hit[1]) begin
                                    evt_c_q <= SC_OWN; // RULE13 RULE15
                                end else if (hit[0]) begin
                                    evt_c_q <= SC_GC; // RULE14 RULE15
                                end else begin
                                    evt_c_q <= SC_ARB;
                                end
                                state_q <= (|hit || lost_q) ? ST_SACK : ST_IDLE;
                            end
                        end
                    end
                    ST_SACK: if (scl_fall) begin
                        if (phase_q == 2'h0) begin
                            sda_oe_q <= ack_drv_q;
                            phase_q <= 2'h1;
                        end else begin
                            sda_oe_q <= 1'b0;
                            scl_oe_q <= 1'b1; // RULE23
                            evt_q <= 1'b1; // RULE15 RULE18
                            state_q <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        scl_oe_q <= 1'b1; // RULE23
                        if (clr_q) begin
                            phase_q <= 2'h0;
                            if (sta_q) begin
                                state_q <= ST_START; // RULE19
                            end else if (mstr_q && sto_q) begin
                                state_q <= ST_STOP;
                            end else if (mstr_q) begin
                                bitcnt_q <= 3'h7;
                                state_q <= ST_TX;
                            end else begin
                                scl_oe_q <= 1'b0;
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_irq_level: assert property (1 |=> irq_q == $past(done_q && ie_q && global_irq_en)) // RULE4
        else $error("irq does not follow job-done and enables");
    chk_status_lag: assert property ($rose(done_q) |=> status_q == $past(evt_c_q)) // RULE24
        else $error("status code not shown one cycle after job-done");
    chk_status_idle: assert property (!done_q |=> status_q == SC_NONE) // RULE24
        else $error("status not idle code while job-done low");
    chk_data_stable: assert property (done_q && !wr_data |=> data_q == $past(data_q)) // RULE9
        else $error("data register changed while job-done set");
    chk_wc_set: assert property (wr_data && !done_q |=> wc_q ##1 wc_q || wr_data) // RULE25
        else $error("collision flag not set on early data write");
    chk_off_release: assert property (!en_q |=> !scl_oe_q && !sda_oe_q && state_q == ST_IDLE) // RULE2
        else $error("pins not released after disable");
    chk_res_zero: assert property (acc && !pready_q && !apb.pwrite && apb.paddr == OFF_CTRL |=> pready_q && prdata_q[1] == 1'b0) // RULE3
        else $error("reserved control bit read as one");
    chk_hold_scl: assert property (done_q && en_q && $past(en_q) |-> scl_oe_q) // RULE23
        else $error("scl released while job-done set");
    chk_no_start: assert property (done_q && en_q |=> $stable(state_q)) // RULE19
        else $error("bus engine moved on while job-done set");
    chk_stop_flag: assert property (state_q == ST_STOP ##1 state_q == ST_IDLE |-> !evt_q ##1 !done_q) // RULE22
        else $error("job-done raised after stop");
    chk_clear_go: assert property (state_q == ST_HOLD && en_q && wr_ctrl && wd[CTL_DONE] && wd[CTL_EN] && done_q |=> clr_q ##1 state_q != ST_HOLD) // RULE26
        else $error("engine did not leave hold after flag clear");
endmodule : tws_core
`default_nettype wire

// ---- logic/tws_pkg.sv ----
// shared constants, codes and types of the two-wire serial register core
package tws_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_RATE = 8'h10;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTL_DONE = 7;
    localparam int CTL_ACKEN = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_WC = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_IE = 0;
    localparam int ADR_GCE = 0;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_ADDR = 8'hfe;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [1:0] RST_PS = 2'h0;
    // ----------------------------------------
    // five-bit status codes
    // ----------------------------------------
    localparam logic [4:0] SC_START = 5'h01;
    localparam logic [4:0] SC_RSTART = 5'h02;
    localparam logic [4:0] SC_AW_ACK = 5'h03;
    localparam logic [4:0] SC_AW_NACK = 5'h04;
    localparam logic [4:0] SC_D_ACK = 5'h05;
    localparam logic [4:0] SC_D_NACK = 5'h06;
    localparam logic [4:0] SC_ARB = 5'h07;
    localparam logic [4:0] SC_OWN = 5'h0c;
    localparam logic [4:0] SC_GC = 5'h0e;
    localparam logic [4:0] SC_NONE = 5'h1f;
    localparam logic [7:0] GC_ADDR = 8'h00;
    // ----------------------------------------
    // timing: quarter bit = base + rate * 4^prescale / 2 cycles
    // ----------------------------------------
    localparam logic [15:0] QTR_BASE = 16'h0004;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_TX, ST_ACK, ST_STOP, ST_SRX, ST_SACK, ST_HOLD
    } tws_state_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tws_apb_req_t;
endpackage : tws_pkg

// ---- verification/tws_slave_model.sv ----
// behavioural slave that acknowledges every ninth bit on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module tws_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    output logic sda_pull
);
    int bits = 0;
    initial sda_pull = 1'b0;
    // a start resets the count so a repeated start cannot shift the ack slot
    always @(negedge sda) if (scl) bits = 0;
    always @(posedge scl) bits = bits + 1;
    always @(negedge scl) sda_pull <= ack_en && (bits % 9 == 8);
endmodule : tws_slave_model
`default_nettype wire

// ---- verification/two_wire_serial_register_core_tb_top.sv ----
// self-checking bench of the two-wire serial register core with a slave model
`timescale 1ns/10ps
`default_nettype none
module two_wire_serial_register_core_tb_top;
    import tws_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic gie = 1'b0;
    logic ack_en = 1'b1;
    tws_apb_req_t apb_q = '0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, filter_en, scl_o, scl_oe, sda_o, sda_oe, pull;
    logic ext_scl = 1'b0;
    logic ext_sda = 1'b0;
    logic ackd;
    // a second master on the bus pulls the lines through ext_scl and ext_sda
    wire logic scl = ~(scl_oe | ext_scl);
    wire logic sda = ~(sda_oe | pull | ext_sda);
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic [7:0] rdv, sla, dat;
    logic [1:0] ps;
    int n_mismatch = 0, num_checks = 0, cyc = 0, seed = 5;
    tws_core u_dut (.sys_clk(sys_clk), .rst(rst), .apb(apb_q), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_en(gie), .irq(irq), .filter_en(filter_en), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    tws_slave_model u_slave (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(pull));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // every access queues its expectation: {slave error, read mask, read value}
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [16:0] x);
        @(posedge sys_clk);
        exp_q.push_back(x);
        apb_q <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge sys_clk);
        apb_q.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdv = prdata[7:0];
        apb_q <= '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 17'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        acc(1'b0, a, 8'h00, {1'b0, m, x});
    endtask : rd
    task automatic wait_done();
        rdv = 8'h00;
        for (int i = 0; i < 400 && rdv[7] !== 1'b1; i++) rd(OFF_CTRL, 8'h00, 8'h00);
    endtask : wait_done
    // another master: start, address byte, ninth clock sampling our ack; scl is left low
    task automatic ext_addr(input logic [8:0] b);
        ext_sda <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 8; i >= 0; i--) begin
            ext_scl <= 1'b1;
            repeat (2) @(posedge sys_clk);
            ext_sda <= !b[i];
            repeat (2) @(posedge sys_clk);
            ext_scl <= 1'b0;
            repeat (4) @(posedge sys_clk);
            if (i == 0) ackd = sda_oe;
        end
        ext_scl <= 1'b1;
    endtask : ext_addr
    always @(posedge sys_clk) if (pready === 1'b1 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        if (e[15:8] != 8'h00) check(prdata[7:0] & e[15:8], e[7:0] & e[15:8]);
        check({7'h0, pslverr}, {7'h0, e[16]});
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // a hung handshake or poll ends here as a failure
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        ps = 2'($random(seed));
        sla = {7'($random(seed)), 1'b0};
        dat = 8'($random(seed));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFF_STAT, 8'hf8, 8'hff);
        rd(OFF_DATA, RST_DATA, 8'hff);
        wr(OFF_ADDR, sla | 8'h01);
        rd(OFF_ADDR, sla | 8'h01, 8'hff);
        wr(OFF_STAT, {6'h3f, ps});
        rd(OFF_STAT, {5'h1f, 1'b0, ps}, 8'hff);
        wr(OFF_RATE, 8'h01);
        wr(OFF_CTRL, 8'h07);
        rd(OFF_CTRL, 8'h05, 8'hff);
        check({7'h0, filter_en}, 8'h01);
        wr(OFF_DATA, 8'h55);
        rd(OFF_CTRL, 8'h0d, 8'hff);
        rd(OFF_DATA, RST_DATA, 8'hff);
        acc(1'b1, 8'h14, 8'h00, 17'h10000);
        gie <= 1'b1;
        wr(OFF_CTRL, 8'ha5);
        wait_done();
        rd(OFF_STAT, {SC_START, 1'b0, ps}, 8'hff);
        check({6'h0, irq, scl_oe}, 8'h03);
        wr(OFF_DATA, sla);
        rd(OFF_CTRL, 8'ha5, 8'hff);
        wr(OFF_CTRL, 8'h85);
        wait_done();
        rd(OFF_STAT, {SC_AW_ACK, 1'b0, ps}, 8'hff);
        rd(OFF_DATA, sla, 8'hff);
        gie <= 1'b0;
        ack_en <= 1'b0;
        wr(OFF_DATA, dat);
        wr(OFF_CTRL, 8'h85);
        wait_done();
        rd(OFF_STAT, {SC_D_NACK, 1'b0, ps}, 8'hff);
        rd(OFF_STAT, {SC_D_NACK, 3'h0}, 8'hf8);
        check({7'h0, irq}, 8'h00);
        wr(OFF_CTRL, 8'h95);
        repeat (60) rd(OFF_CTRL, 8'h00, 8'h80);
        // addressed as a slave by the other master, with ack enabled
        wr(OFF_CTRL, 8'hc5);
        ext_addr({sla, 1'b1});
        check({7'h0, ackd}, 8'h01);
        wait_done();
        rd(OFF_STAT, {SC_OWN, 1'b0, ps}, 8'hff);
        rd(OFF_DATA, sla, 8'hff);
        wr(OFF_CTRL, 8'h85);
        ext_sda <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_scl <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ext_sda <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(OFF_CTRL, 8'ha4);
        repeat (6) @(posedge sys_clk);
        wr(OFF_CTRL, 8'h00);
        repeat (2) @(posedge sys_clk);
        check({3'h0, scl_o, sda_o, scl_oe, sda_oe, filter_en}, 8'h00);
        end_of_test();
    end
endmodule : two_wire_serial_register_core_tb_top
`default_nettype wire
